// ### rtl/fso_top.sv
// Flash option shadow, key-write configuration and security gating.
// Assumes an APB master on clk_sys and a processor write port on the same clock;
// the nonvolatile option byte and key are stable while reset is high.
//
// The APB interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module fso_top
  import fso_pkg::*;
(
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              reset,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Nonvolatile contents
  input  wire logic [7:0]        nvOptionByte,
  input  wire logic [63:0]       nvBackdoorKey,
  // Processor memory write port
  input  wire logic              memWrValid,
  input  wire logic [15:0]       memWrAddr,
  input  wire logic [7:0]        memWrData,
  input  wire logic              memWrFromDebug,
  // Flash command start
  output logic                   cmdStartPulse,
  output logic [15:0]            cmdStartAddr,
  output logic [7:0]             cmdStartData,
  // Blank check result
  input  wire logic              blankCheckErased,
  // Memory access gating
  input  wire logic              memAccReq,
  input  wire logic              memAccFromUnsecured,
  output logic                   memAccAllow,
  // Status
  output logic                   secure,
  output logic                   redirectDisable,
  output logic                   backdoorEnable
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [7:0] flashOptionShadow;
  logic [7:0] flashKeyConfig;
  logic       keyWriteSelect;
  logic       inKeyWindow;
  logic       keyStrobe;
  logic       keyMatch;
  logic       unlock;

  assign keyWriteSelect  = flashKeyConfig[CFG_KEYSEL_BIT];
  assign backdoorEnable  = flashOptionShadow[OPT_KEY_EN_BIT];
  assign redirectDisable = flashOptionShadow[OPT_NORED_BIT];
  assign secure          = (flashOptionShadow[1:0] != CODE_UNSECURED);

  // ****************************************************************
  // APB decode
  // ****************************************************************
  logic accessPhase;
  logic setupPhase;
  logic hitOpt;
  logic hitCfg;

  assign setupPhase  = psel && !penable;
  assign accessPhase = psel && penable;
  assign hitOpt      = (paddr == OPT_BYTE_ADDR);
  assign hitCfg      = (paddr == CFG_BYTE_ADDR);
  // Zero wait states; unmapped addresses answer with an error
  assign pready      = 1'b1;
  assign pslverr     = accessPhase && !(hitOpt || hitCfg);

  // Read data captured in the setup cycle so it comes from a flop
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      prdata <= 32'h0000_0000;
    else if (setupPhase)
    begin
      if (hitOpt)
        prdata <= {24'h00_0000, flashOptionShadow & OPT_READ_MASK};
      else if (hitCfg)
        prdata <= {24'h00_0000, flashKeyConfig & CFG_WRITE_MASK};
      else
        prdata <= 32'h0000_0000;
    end
  end

  // ****************************************************************
  // Option shadow
  // ****************************************************************
  // No bus write path exists: settings change only through the NV byte and a reset, except the code bits, which unlock or a blank check set to unsecured
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      flashOptionShadow <= nvOptionByte & OPT_READ_MASK;
    else if (unlock || blankCheckErased)
      flashOptionShadow[1:0] <= CODE_UNSECURED;
  end

  // ****************************************************************
  // Key configuration
  // ****************************************************************
  always_ff @(posedge clk_sys)
  begin
    if (reset)
      flashKeyConfig <= CFG_RESET;
    else if (accessPhase && pwrite && hitCfg && pstrb[0])
      flashKeyConfig <= pwdata[7:0] & CFG_WRITE_MASK;
  end

  // ****************************************************************
  // Key window steering
  // ****************************************************************
  assign inKeyWindow = memWrValid && (memWrAddr >= KEY_BASE_ADDR)
                       && (memWrAddr <= KEY_LAST_ADDR);
  // Debug-port writes never reach the comparator
  assign keyStrobe   = inKeyWindow && keyWriteSelect && !memWrFromDebug;

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      cmdStartPulse <= 1'b0;
      cmdStartAddr  <= 16'h0000;
      cmdStartData  <= 8'h00;
    end
    else
    begin
      cmdStartPulse <= inKeyWindow && !keyWriteSelect;
      if (inKeyWindow && !keyWriteSelect)
      begin
        cmdStartAddr <= memWrAddr;
        cmdStartData <= memWrData;
      end
    end
  end

  fso_key_match #(
    .NUM_BYTES (KEY_BYTES)
  ) fso_key_match_i (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wrStrobe   (keyStrobe),
    .byteIdx    (memWrAddr[2:0]),
    .wrData     (memWrData),
    .keyValue   (nvBackdoorKey),
    .matchPulse (keyMatch)
  );

  // Unlock holds until reset because nothing else rewrites the code
  assign unlock = keyMatch && backdoorEnable;

  // ****************************************************************
  // Access gating
  // ****************************************************************
  assign memAccAllow = memAccReq && !(secure && memAccFromUnsecured);

endmodule : fso_top

`default_nettype wire

// ### rtl/fso_pkg.sv
// Constants shared by the flash security and option block.
// Assumes an APB master with 32-bit data and a 16-bit byte address.
`default_nettype none

package fso_pkg;

  // ****************************************************************
  // Register indices and byte addresses
  // ****************************************************************
  localparam int           ADDR_W          = 16;
  localparam logic [15:0]  OPT_INDEX       = 16'h1821;
  localparam logic [15:0]  CFG_INDEX       = 16'h1823;
  localparam logic [15:0]  OPT_BYTE_ADDR   = 16'(OPT_INDEX * 4);
  localparam logic [15:0]  CFG_BYTE_ADDR   = 16'(CFG_INDEX * 4);

  // ****************************************************************
  // Field positions, masks and reset values
  // ****************************************************************
  localparam int           OPT_KEY_EN_BIT  = 7;
  localparam int           OPT_NORED_BIT   = 6;
  localparam logic [7:0]   OPT_READ_MASK   = 8'hC3;
  localparam logic [1:0]   CODE_UNSECURED  = 2'h2;
  localparam int           CFG_KEYSEL_BIT  = 5;
  localparam logic [7:0]   CFG_WRITE_MASK  = 8'hE0;
  localparam logic [7:0]   CFG_RESET       = 8'h00;

  // ****************************************************************
  // Backdoor key window
  // ****************************************************************
  localparam int           KEY_BYTES       = 8;
  localparam logic [15:0]  KEY_BASE_ADDR   = 16'hFFB0;
  localparam logic [15:0]  KEY_LAST_ADDR   = 16'hFFB7;

endpackage : fso_pkg

`default_nettype wire

// ### rtl/fso_key_match.sv
// Backdoor key comparator: counts eight key writes and flags a full match.
// Assumes writes arrive as one-cycle strobes on clk_sys, already filtered.
`timescale 1ns/1ps
`default_nettype none

module fso_key_match
  import fso_pkg::*;
#(
  parameter int NUM_BYTES = KEY_BYTES
)
(
  // Clock and reset
  input  wire logic                     clk_sys,
  input  wire logic                     reset,
  // Key write strobe
  input  wire logic                     wrStrobe,
  input  wire logic [$clog2(NUM_BYTES)-1:0] byteIdx,
  input  wire logic [7:0]               wrData,
  // Stored key, byte 0 in the low bits
  input  wire logic [NUM_BYTES*8-1:0]   keyValue,
  // Result
  output logic                          matchPulse
);

  localparam int IW = $clog2(NUM_BYTES);
  localparam logic [IW-1:0] LAST_IDX = IW'(NUM_BYTES - 1);

  logic [IW-1:0] expectIdx;
  logic          allOk;
  logic          byteHit;

  // A byte counts only at its own slot, so bytes must come in ascending order
  assign byteHit = (byteIdx == expectIdx) && (wrData == keyValue[byteIdx*8 +: 8]);

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      expectIdx  <= '0;
      allOk      <= 1'b1;
      matchPulse <= 1'b0;
    end
    else
    begin
      matchPulse <= 1'b0;
      if (wrStrobe)
      begin
        if (expectIdx == LAST_IDX)
        begin
          // A failed attempt just rearms the comparator
          matchPulse <= allOk && byteHit;
          expectIdx  <= '0;
          allOk      <= 1'b1;
        end
        else
        begin
          expectIdx <= expectIdx + IW'(1);
          allOk     <= allOk && byteHit;
        end
      end
    end
  end

endmodule : fso_key_match

`default_nettype wire

// ### tb/fso_props.sv
// Checker for the flash security block, watching the top ports only.
// Assumes one clock domain with a synchronous active-high reset.
`timescale 1ns/1ps
`default_nettype none

module fso_props
  import fso_pkg::*;
(
  // Clock and reset
  input wire logic              clk_sys,
  input wire logic              reset,
  // Bus and write port
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0]       prdata,
  input wire logic              memWrValid,
  input wire logic [15:0]       memWrAddr,
  input wire logic              cmdStartPulse,
  // Security side
  input wire logic              blankCheckErased,
  input wire logic              memAccReq,
  input wire logic              memAccFromUnsecured,
  input wire logic              memAccAllow,
  input wire logic              secure,
  input wire logic              redirectDisable,
  input wire logic              backdoorEnable
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  gate_rule_a:
    assert property (memAccAllow == (memAccReq && !(secure && memAccFromUnsecured)))
    else $error("memory gating wrong");
  opt_stable_a:
    assert property ($stable(redirectDisable) && $stable(backdoorEnable))
    else $error("option bits moved outside reset");
  key_off_lock_a:
    assert property (secure && !backdoorEnable && !blankCheckErased |=> secure)
    else $error("unlocked with backdoor disabled");
  blank_unlock_a:
    assert property (blankCheckErased |=> !secure) else $error("blank check kept lock");
  unlock_hold_a:
    assert property (!secure |=> !secure) else $error("relocked before reset");
  cmd_cause_a:
    assert property (cmdStartPulse |-> $past(memWrValid) && ($past(memWrAddr) >> 3) == 16'h1FF6)
    else $error("command start without window write");
  opt_zero_a:
    assert property (psel && penable && !pwrite && paddr == OPT_BYTE_ADDR |-> prdata[5:2] == 4'h0)
    else $error("option unused bits not zero");
  cfg_zero_a:
    assert property (psel && penable && !pwrite && paddr == CFG_BYTE_ADDR |-> prdata[4:0] == 5'h00)
    else $error("config low bits not zero");
endmodule : fso_props

bind fso_top fso_props fso_props_i (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr,
  .prdata, .memWrValid, .memWrAddr, .cmdStartPulse, .blankCheckErased, .memAccReq,
  .memAccFromUnsecured, .memAccAllow, .secure, .redirectDisable, .backdoorEnable);

`default_nettype wire

// ### tb/fso_top_tb.sv
// Self-checking bench for the flash security block with a small model.
// Assumes APB answers when pready is high; the key is drawn from a fixed seed, so it is the same every run.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin nTests++; if ((s) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, s); end end

module fso_top_tb
  import fso_pkg::*;
;
  logic        clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
  logic [15:0] paddr = 0, memWrAddr = 0, cmdStartAddr;
  logic [31:0] pwdata = 0, prdata, r;
  logic [7:0]  nvOptionByte = 0, memWrData = 0, cmdStartData, nv;
  logic [63:0] key;
  logic        memWrValid = 0, memWrFromDebug = 0, blankCheckErased = 0, memAccReq = 0;
  logic        memAccFromUnsecured = 0, memAccAllow, secure, redirectDisable, backdoorEnable;
  logic        cmdStartPulse, slvErr;
  int          seed = 64112, fails = 0, nTests = 0, mOpt = 0;

  fso_top fso_top_i (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .nvOptionByte, .nvBackdoorKey(key),
    .memWrValid, .memWrAddr, .memWrData, .memWrFromDebug, .cmdStartPulse, .cmdStartAddr,
    .cmdStartData, .blankCheckErased, .memAccReq, .memAccFromUnsecured, .memAccAllow,
    .secure, .redirectDisable, .backdoorEnable);

  // ****************************************************************
  // Model and drivers
  // ****************************************************************
  function automatic logic mSecure();
    return 1'((mOpt & 3) != 2);
  endfunction : mSecure

  task automatic rst(input logic [7:0] v);
    @(posedge clk_sys);
    reset <= 1;
    nvOptionByte <= v;
    memAccReq <= v[3];
    memAccFromUnsecured <= v[2];
    mOpt = v & 8'hC3;
    repeat (12) @(posedge clk_sys);
    reset <= 0;
  endtask : rst

  task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'hFFFFFF, d};
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    slvErr = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb

  // Valid stays high across the eight bytes so no strobe is driven twice in one step
  task automatic key8(input logic [63:0] k, input logic dbg);
    @(posedge clk_sys);
    memWrValid <= 1;
    memWrFromDebug <= dbg;
    for (int i = 0; i < 8; i++)
    begin
      memWrAddr <= KEY_BASE_ADDR + 16'(i);
      memWrData <= k[8*i+:8];
      @(posedge clk_sys);
    end
    memWrValid <= 0;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : key8

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up

  // ****************************************************************
  // Sequence
  // ****************************************************************
  initial
  begin
    forever #4 clk_sys = ~clk_sys;
  end

  initial
  begin
    repeat (5000) @(posedge clk_sys);
    fails++;
    wrap_up;
  end

  initial
  begin
    key = {$random(seed), $random(seed)};
    for (int c = 0; c < 4; c++)
    begin
      nv = 8'($random(seed)) & 8'hFC | 8'(c);
      rst(nv);
      apb(1, OPT_BYTE_ADDR, 8'hFF);
      apb(0, OPT_BYTE_ADDR, 8'h00);
      #1;
      `CHK("option", 32'(mOpt), r)
      `CHK("secure", mSecure(), secure)
      `CHK("redirect", nv[6], redirectDisable)
      `CHK("keyEnable", nv[7], backdoorEnable)
      `CHK("gate", memAccReq & ~(mSecure() & memAccFromUnsecured), memAccAllow)
    end
    rst(8'h4D);
    apb(1, CFG_BYTE_ADDR, 8'hFF);
    apb(0, CFG_BYTE_ADDR, 8'h00);
    `CHK("config", 32'hE0, r)
    apb(0, 16'h0000, 8'h00);
    `CHK("slverr", 1'b1, slvErr)
    `CHK("pready", 1'b1, pready)
    key8(key, 0);
    `CHK("locked", mSecure(), secure)
    rst(8'h8D);
    @(posedge clk_sys);
    memWrValid <= 1;
    memWrAddr <= 16'hFFB3;
    memWrData <= 8'h5A;
    @(posedge clk_sys);
    memWrValid <= 0;
    #1;
    `CHK("cmdPulse", 1'b1, cmdStartPulse)
    `CHK("cmdAddr", 16'hFFB3, cmdStartAddr)
    `CHK("cmdData", 8'h5A, cmdStartData)
    apb(1, CFG_BYTE_ADDR, 8'h20);
    key8(key, 1);
    `CHK("debugKey", mSecure(), secure)
    key8(key ^ {8'h01, 56'h0}, 0);
    `CHK("badKey", mSecure(), secure)
    key8(key, 0);
    mOpt = mOpt & 8'hFC | 2;
    `CHK("goodKey", mSecure(), secure)
    apb(0, OPT_BYTE_ADDR, 8'h00);
    `CHK("unlockCode", 32'(mOpt), r)
    `CHK("gateOpen", memAccReq, memAccAllow)
    rst(8'h00);
    blankCheckErased <= 1;
    @(posedge clk_sys);
    blankCheckErased <= 0;
    #1;
    mOpt = 2;
    `CHK("blank", mSecure(), secure)
    wrap_up;
  end
endmodule : fso_top_tb

`default_nettype wire
